/* File: logic/clkctl_defs.svh */
// register map, field positions, reset values and sizes for clock control
`ifndef CLKCTL_DEFS_SVH
`define CLKCTL_DEFS_SVH

// register byte offsets
`define CC_CTRL_OFS     8'h00
`define CC_BYP_OFS      8'h04
`define CC_SEL0_OFS     8'h08
`define CC_SEL3_OFS     8'h14
`define CC_STAT_OFS     8'h18

// register index codes
`define CC_IDX_CTRL     3'h0
`define CC_IDX_BYP      3'h1
`define CC_IDX_SEL      3'h2
`define CC_IDX_STAT     3'h3
`define CC_IDX_NONE     3'h7

// sizes
`define CC_NUM_SCLK     32
`define CC_NUM_CEN      8
`define CC_NUM_CTR      9
`define CC_SEL_W        3
`define CC_SEL_PER_WORD 8

// field widths and positions
`define CC_CTRL_W       12
`define CC_STAT_CTR_LSB 0
`define CC_STAT_DIV_LSB 9
`define CC_STAT_CEN_LSB 11

// reset values
`define CC_CTRL_RST     12'h000
`define CC_BYP_RST      32'hFFFFFFFF
`define CC_SEL_RST      3'h0

`endif

/* File: logic/clkctl_pkg.sv */
// types shared by the clock control block
`default_nettype none
package clkctl_pkg;

   // treatment of the incoming clock in the periphery mux
   typedef enum logic [1:0] {
      MODE_PASS = 2'b00,
      MODE_ROOT = 2'b01,
      MODE_DIV  = 2'b11
   } mode_e;

   // divider output picked for the periphery mux output
   typedef enum logic [1:0] {
      DIV_BY1 = 2'b00,
      DIV_BY2 = 2'b01,
      DIV_BY4 = 2'b11
   } dsel_e;

   // control register layout
   typedef struct packed {
      logic [3:0] root_ctr;
      logic [3:0] src_sel;
      dsel_e      div_sel;
      mode_e      mode;
   } ctrl_s;

endpackage : clkctl_pkg
`default_nettype wire

/* File: logic/fabric_clock_gating_divider.sv */
// clock mux, divider, root, sector and pll gates with an ahb-lite slave
`include "clkctl_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module fabric_clock_gating_divider #(
   parameter int SECTORS = 2,
   parameter int DW      = 8
) (
   // clock and reset
   input  wire logic                           hclk,
   input  wire logic                           hresetn,
   // ahb-lite slave
   input  wire logic                           hsel,
   input  wire logic [31:0]                    haddr,
   input  wire logic [1:0]                     htrans,
   input  wire logic                           hwrite,
   input  wire logic [2:0]                     hsize,
   input  wire logic                           hready,
   input  wire logic [31:0]                    hwdata,
   output      logic                           hreadyout,
   output      logic                           hresp,
   output      logic [31:0]                    hrdata,
   // pll counter clock ticks and their gate enables
   input  wire logic [`CC_NUM_CTR-1:0]         pll_tick,
   input  wire logic [`CC_NUM_CTR-1:0]         pll_ena,
   output      logic [`CC_NUM_CTR-1:0]         pll_out,
   // core-driven gate enables
   input  wire logic                           root_ena,
   input  wire logic [`CC_NUM_CEN-1:0]         sector_ena,
   // periphery mux and divider outputs
   output      logic                           mux_tick,
   output      logic [2:0]                     div_tick,
   // sector clock ticks, sector-major
   output      logic [SECTORS*`CC_NUM_SCLK-1:0] sclk_tick,
   // functional clock enable register
   input  wire logic [DW-1:0]                  reg_d,
   input  wire logic                           reg_ce,
   output      logic [DW-1:0]                  reg_q
);

   // ****************************************************************
   // register decode
   // ****************************************************************

   // map, one aligned word each:
   //   ctrl  mode [1:0], divider pick [3:2], source [7:4], root counter
   //         [11:8]; mode code 2'b10 and pick code 2'b10 act as pass and /1
   //   byp   bit i set skips gate i and forwards the clock as it is
   //   sel   four words, three bits per gate, eight gates per word; the
   //         field names which of the eight core enables drives the gate
   //   stat  read only: synced pll enables, divider phase, sector 0 enables
   // unmapped offsets read zero and ignore writes, so software probing
   // the map never disturbs a running clock

   // maps a byte offset onto a register index, used by read and write;
   // sel words are only recognised when aligned to a word boundary
   function automatic logic [2:0] reg_index(input logic [7:0] ofs);
      logic [2:0] idx;
      idx = `CC_IDX_NONE;
      if (ofs == `CC_CTRL_OFS) begin
         idx = `CC_IDX_CTRL;
      end else if (ofs == `CC_BYP_OFS) begin
         idx = `CC_IDX_BYP;
      end else if (ofs >= `CC_SEL0_OFS && ofs <= `CC_SEL3_OFS
                   && ofs[1:0] == 2'h0) begin
         idx = `CC_IDX_SEL;
      end else if (ofs == `CC_STAT_OFS) begin
         idx = `CC_IDX_STAT;
      end
      return idx;
   endfunction : reg_index

   // word number inside the select bank; subtract at full offset width
   // first, so the result never wraps past the end of the bank
   function automatic logic [1:0] sel_word(input logic [7:0] ofs);
      logic [7:0] rel;
      rel = ofs - `CC_SEL0_OFS;
      return rel[3:2];
   endfunction : sel_word

   // ****************************************************************
   // ahb-lite slave
   // ****************************************************************

   clkctl_pkg::ctrl_s       ctrl_ff;
   logic [`CC_NUM_SCLK-1:0] byp_ff;
   logic [`CC_SEL_W-1:0]    sel_ff [`CC_NUM_SCLK];
   logic                    wr_pend_ff;
   logic [7:0]              waddr_ff;
   logic [31:0]             rdata_ff;
   logic                    addr_ok;
   logic [31:0]             nxt_rdata;
   logic [31:0]             stat_w;
   logic [1:0]              word_sel;
   logic [1:0]              div_cnt_ff;
   logic [`CC_NUM_CTR-1:0]  pll_s1_ff;
   logic [`CC_NUM_CTR-1:0]  pll_s2_ff;
   logic [`CC_NUM_CEN-1:0]  sena_ff [SECTORS];

   // zero wait states, every answer okay
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_ff;
   assign addr_ok   = hsel & htrans[1] & hready;

   // write address caught in address phase, data taken in data phase;
   // a read of the same register in that data phase still sees the old
   // value, since the read word is latched on the same edge the write lands
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         waddr_ff   <= 8'h00;
      end else begin
         wr_pend_ff <= addr_ok & hwrite;
         if (addr_ok) begin
            waddr_ff <= haddr[7:0];
         end
      end
   end

   // status word shows synced pll enables, divider phase, sector enables;
   // only sector 0 is shown, as every copy samples the same core wires
   // on the same edge, so all copies hold the same value
   always_comb begin
      stat_w = 32'h00000000;
      stat_w[`CC_STAT_CTR_LSB +: `CC_NUM_CTR] = pll_s2_ff;
      stat_w[`CC_STAT_DIV_LSB +: 2]           = div_cnt_ff;
      stat_w[`CC_STAT_CEN_LSB +: `CC_NUM_CEN] = sena_ff[0];
   end

   // read mux, registered so data stands in the data phase; the word is
   // caught on the address-phase edge and then held until the next read,
   // which keeps hrdata steady while the master samples it
   always_comb begin
      nxt_rdata = 32'h00000000;
      word_sel  = sel_word(haddr[7:0]);
      unique case (reg_index(haddr[7:0]))
         `CC_IDX_CTRL: nxt_rdata[`CC_CTRL_W-1:0] = ctrl_ff;
         `CC_IDX_BYP:  nxt_rdata = byp_ff;
         `CC_IDX_SEL: begin
            for (int j = 0; j < `CC_SEL_PER_WORD; j++) begin
               nxt_rdata[j*`CC_SEL_W +: `CC_SEL_W] =
                  sel_ff[int'(word_sel)*`CC_SEL_PER_WORD + j];
            end
         end
         `CC_IDX_STAT: nxt_rdata = stat_w;
         default:      nxt_rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_ff <= 32'h00000000;
      end else if (addr_ok && !hwrite) begin
         rdata_ff <= nxt_rdata;
      end
   end

   // control and bypass registers; bypass resets to all ones so clocks
   // flow to every sector until software has set up the enable selects
   // and the core has driven sensible enables
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ff <= `CC_CTRL_RST;
         byp_ff  <= `CC_BYP_RST;
      end else if (wr_pend_ff) begin
         if (reg_index(waddr_ff) == `CC_IDX_CTRL) begin
            ctrl_ff <= hwdata[`CC_CTRL_W-1:0];
         end
         if (reg_index(waddr_ff) == `CC_IDX_BYP) begin
            byp_ff <= hwdata;
         end
      end
   end

   // enable selects: three bits per gate, so only eight enables exist;
   // the limit is structural, so no write can ever name a ninth enable
   // and gates beyond eight must share
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < `CC_NUM_SCLK; i++) begin
            sel_ff[i] <= `CC_SEL_RST;
         end
      end else if (wr_pend_ff && reg_index(waddr_ff) == `CC_IDX_SEL) begin
         for (int j = 0; j < `CC_SEL_PER_WORD; j++) begin
            sel_ff[int'(sel_word(waddr_ff))*`CC_SEL_PER_WORD + j]
               <= hwdata[j*`CC_SEL_W +: `CC_SEL_W];
         end
      end
   end

   // ****************************************************************
   // pll output counter gates
   // ****************************************************************

   // enables come from another domain; two flops before any use.
   // the first flop may go metastable, so only the second is read,
   // both by the gate and by the status word
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pll_s1_ff <= '0;
         pll_s2_ff <= '0;
      end else begin
         pll_s1_ff <= pll_ena;
         pll_s2_ff <= pll_s1_ff;
      end
   end

   // one independent gate per counter; the enable reaches the gate two
   // edges after it is sampled, three when the first flop catches it late,
   // so software must never count on an exact cycle here; the gate only
   // ever drops or passes whole ticks, so no shortened pulse can escape
   assign pll_out = pll_tick & pll_s2_ff;

   // ****************************************************************
   // periphery mux: pass, root gate or divider
   // ****************************************************************

   logic src_tick;
   logic root_en_ff;
   logic root_tick;
   logic root_hit;

   // incoming clock picked from the gated pll counters
   always_comb begin
      src_tick = 1'b0;
      for (int k = 0; k < `CC_NUM_CTR; k++) begin
         if (ctrl_ff.src_sel == 4'(k)) begin
            src_tick = pll_out[k];
         end
      end
   end

   // root enable from core; one flop of latency, core must allow more.
   // this gate sits far from the core in silicon, so it is meant for
   // slow on/off control; cycle-exact gating belongs to the sector gates
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         root_en_ff <= 1'b0;
      end else begin
         root_en_ff <= root_ena;
      end
   end

   // only the one chosen counter is gated, others pass untouched
   assign root_hit  = (ctrl_ff.src_sel == ctrl_ff.root_ctr);
   assign root_tick = src_tick & (root_en_ff | ~root_hit);

   // divider counter counts incoming ticks from a common zero; the phase
   // is visible in stat so software can tell where a /4 edge will fall.
   // the counter only moves on source ticks, so a stalled source freezes
   // all three outputs together and they stay aligned when it restarts
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt_ff <= 2'h0;
      end else if (src_tick) begin
         div_cnt_ff <= div_cnt_ff + 2'h1;
      end
   end

   // slow ticks only fire together with a faster tick
   assign div_tick[0] = src_tick;
   assign div_tick[1] = src_tick & ~div_cnt_ff[0];
   assign div_tick[2] = src_tick & (div_cnt_ff == 2'h0);

   // exactly one treatment; divider outputs bypass the root gate.
   // the divider is fed from the ungated source on purpose: gating its
   // output at the root would break alignment, so slow clocks are gated
   // at the sector gates instead
   always_comb begin
      unique case (ctrl_ff.mode)
         clkctl_pkg::MODE_PASS: mux_tick = src_tick;
         clkctl_pkg::MODE_ROOT: mux_tick = root_tick;
         clkctl_pkg::MODE_DIV: begin
            unique case (ctrl_ff.div_sel)
               clkctl_pkg::DIV_BY2: mux_tick = div_tick[1];
               clkctl_pkg::DIV_BY4: mux_tick = div_tick[2];
               default:             mux_tick = div_tick[0];
            endcase
         end
         default: mux_tick = src_tick; // reserved code falls back to pass
      endcase
   end

   // ****************************************************************
   // sector clock gates, one copy per sector
   // ****************************************************************

   // a switchover mux is core logic; the sector gates see only mux_tick.
   // the latch of a real gate is modelled as a rising-edge sample: with
   // ticks standing for clock pulses, the enable can then only change
   // between pulses, which is what the latch guarantees in silicon
   for (genvar s = 0; s < SECTORS; s++) begin : g_sector
      // per-sector copy of the enables, fed from the same core wires
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            sena_ff[s] <= '0;
         end else begin
            sena_ff[s] <= sector_ena;
         end
      end
      for (genvar i = 0; i < `CC_NUM_SCLK; i++) begin : g_sclk
         // held enable changes only between ticks, never mid-pulse
         assign sclk_tick[s*`CC_NUM_SCLK + i] =
            mux_tick & (byp_ff[i] | sena_ff[s][sel_ff[i]]);
      end
   end

   // ****************************************************************
   // functional clock enable register
   // ****************************************************************

   // clock keeps running; low enable recirculates the stored word.
   // this saves no power, as the flop still sees every clock edge; it
   // only freezes the data, so a real clock stop needs one of the gates
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         reg_q <= '0;
      end else begin
         reg_q <= reg_ce ? reg_d : reg_q;
      end
   end

endmodule : fabric_clock_gating_divider
`default_nettype wire

/* File: bench/clkctl_asserts.sv */
// port checker for the clock control block
`timescale 1ns/1ps
`default_nettype none
module clkctl_asserts #(
   parameter int SECTORS = 2,
   parameter int DW      = 8
) (
   // clock and reset
   input wire logic                  hclk,
   input wire logic                  hresetn,
   // gates and divider
   input wire logic [8:0]            pll_tick,
   input wire logic [8:0]            pll_ena,
   input wire logic [8:0]            pll_out,
   input wire logic                  mux_tick,
   input wire logic [2:0]            div_tick,
   input wire logic [SECTORS*32-1:0] sclk_tick,
   // functional enable register
   input wire logic [DW-1:0]         reg_d,
   input wire logic                  reg_ce,
   input wire logic [DW-1:0]         reg_q
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ************************************************
   // source ticks seen since the last divide-by-4 tick
   // ************************************************
   logic [1:0] ph_ff;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_ff <= 2'h0;
      end else if (div_tick[0]) begin
         ph_ff <= ph_ff + 2'h1;
      end
   end
   // every treatment only passes or drops source ticks
   property p_mux_src; mux_tick |-> div_tick[0]; endproperty
   a_mux_src: assert property (p_mux_src)
      else $error("mux tick without source tick");
   // phase fixed by reset, so all three fire on the first tick
   property p_div_ph;
      div_tick[0] |-> div_tick[2] == (ph_ff == 2'h0)
         && div_tick[1] == !ph_ff[0];
   endproperty
   a_div_ph: assert property (p_div_ph)
      else $error("divider phase wrong");
   property p_div_edge; div_tick[2] |-> div_tick[1]; endproperty
   a_div_edge: assert property (p_div_edge)
      else $error("slow edge not aligned");
   property p_sclk;
      (sclk_tick & ~{(SECTORS*32){mux_tick}}) == '0;
   endproperty
   a_sclk: assert property (p_sclk)
      else $error("sector tick without mux tick");
   property p_pll_gate; (pll_out & ~pll_tick) == 9'h000; endproperty
   a_pll_gate: assert property (p_pll_gate)
      else $error("pll tick invented");
   // two-flop sync: nothing passes before the enable is settled
   property p_pll_off;
      (pll_out & ~($past(pll_ena, 2) | $past(pll_ena, 3))) == 9'h000;
   endproperty
   a_pll_off: assert property (p_pll_off)
      else $error("pll gate opened early");
   property p_pll_on;
      (pll_tick & $past(pll_ena, 2) & $past(pll_ena, 3) & ~pll_out) == 9'h000;
   endproperty
   a_pll_on: assert property (p_pll_on)
      else $error("pll gate stayed shut");
   property p_reg_hold; !reg_ce |=> $stable(reg_q); endproperty
   a_reg_hold: assert property (p_reg_hold)
      else $error("register changed while disabled");
   property p_reg_load; reg_ce |=> reg_q == $past(reg_d); endproperty
   a_reg_load: assert property (p_reg_load)
      else $error("register missed its load");
   c_div4: cover property (div_tick[2]);
   c_sclk: cover property (sclk_tick[1] && !sclk_tick[0]);
   c_pll: cover property (pll_out[1] && !pll_out[0]);
endmodule : clkctl_asserts
bind fabric_clock_gating_divider clkctl_asserts #(
   .SECTORS(SECTORS), .DW(DW)
) u_chk (
   .hclk(hclk), .hresetn(hresetn), .pll_tick(pll_tick),
   .pll_ena(pll_ena), .pll_out(pll_out), .mux_tick(mux_tick),
   .div_tick(div_tick), .sclk_tick(sclk_tick), .reg_d(reg_d),
   .reg_ce(reg_ce), .reg_q(reg_q)
);
`default_nettype wire

/* File: bench/core_ena_model.sv */
// core user logic that drives the gate enables
`timescale 1ns/1ps
`default_nettype none
module core_ena_model (
   // clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // levels the bench asks for
   input  wire logic       want_root,
   input  wire logic [7:0] want_sec,
   input  wire logic [8:0] want_pll,
   // enables toward the gates
   output logic            root_ena,
   output logic [7:0]      sector_ena,
   output logic [8:0]      pll_ena
);
   // registered like real core logic; the bench then waits several cycles
   // before it expects the gates to answer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         root_ena   <= 1'b0;
         sector_ena <= 8'h00;
         pll_ena    <= 9'h000;
      end else begin
         root_ena   <= want_root;
         sector_ena <= want_sec;
         pll_ena    <= want_pll;
      end
   end
endmodule : core_ena_model
`default_nettype wire

/* File: bench/fabric_clock_gating_divider_test.sv */
// self-checking bench for the clock control block
`timescale 1ns/1ps
`default_nettype none
module fabric_clock_gating_divider_test;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2, div_tick;
   logic hready, hreadyout, hresp, mux_tick, root_ena, reg_ce = 1'b0;
   logic [8:0] pll_tick = 9'h000, pll_ena, pll_out, want_pll = 9'h000;
   logic [7:0] sector_ena, want_sec = 8'h00, reg_d = 8'h00, reg_q;
   logic [63:0] sclk_tick;
   logic want_root = 1'b0, clr = 1'b0;
   logic [5:0] v;
   int cnt[6], mismatches = 0, n_checks = 0;
   assign hready = hreadyout;
   assign v = {sclk_tick[32], sclk_tick[1], sclk_tick[0],
               div_tick[2], div_tick[1], mux_tick};
   always #2 hclk = ~hclk;
   fabric_clock_gating_divider uut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
      .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .pll_tick(pll_tick), .pll_ena(pll_ena),
      .pll_out(pll_out), .root_ena(root_ena), .sector_ena(sector_ena),
      .mux_tick(mux_tick), .div_tick(div_tick), .sclk_tick(sclk_tick),
      .reg_d(reg_d), .reg_ce(reg_ce), .reg_q(reg_q));
   core_ena_model core (
      .hclk(hclk), .hresetn(hresetn), .want_root(want_root),
      .want_sec(want_sec), .want_pll(want_pll), .root_ena(root_ena),
      .sector_ena(sector_ena), .pll_ena(pll_ena));
   // tick counters, cleared between bursts; sampled mid-cycle where the
   // outputs have settled, and an unknown tick counts so it cannot hide
   always @(negedge hclk) begin
      foreach (cnt[i]) cnt[i] = clr ? 0 : cnt[i] + ((v[i] !== 1'b0) ? 1 : 0);
   end
   // ************************************************
   // tasks
   // ************************************************
   task automatic finish_test;
      if (mismatches == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : finish_test
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // bounded wait for the slave's ready
   task automatic wait_rdy;
      int t;
      t = 0;
      @(posedge hclk);
      while (hready !== 1'b1 && t < 50) begin
         t++;
         @(posedge hclk);
      end
      if (t >= 50) begin
         mismatches++;
         finish_test();
      end
   endtask : wait_rdy
   // one single transfer; an idle edge first keeps drives one per step
   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {24'h0, a};
      hwrite <= wr;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      rdv = hrdata;
   endtask : ahb
   task automatic setc(input clkctl_pkg::mode_e m,
                       input clkctl_pkg::dsel_e d, input logic [3:0] s,
                       input logic [3:0] r);
      ahb(1'b1, 8'h00, {20'h0, r, s, d, m});
   endtask : setc
   // eight source ticks, every other cycle, after enables settle
   task automatic burst;
      repeat (6) @(posedge hclk);
      clr <= 1'b1;
      @(posedge hclk);
      clr <= 1'b0;
      repeat (8) begin
         pll_tick <= 9'h1FF;
         @(posedge hclk);
         pll_tick <= 9'h000;
         @(posedge hclk);
      end
      @(posedge hclk);
   endtask : burst
   task automatic cc(input int i, input int e);
      check(32'(cnt[i]), 32'(e));
   endtask : cc
   // ************************************************
   // main sequence
   // ************************************************
   initial begin
      clkctl_pkg::dsel_e ds[3];
      ds = '{clkctl_pkg::DIV_BY1, clkctl_pkg::DIV_BY2, clkctl_pkg::DIV_BY4};
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, 8'h00, 32'h0);
      check(rdv, 32'h0);
      ahb(1'b0, 8'h04, 32'h0);
      check(rdv, 32'hFFFFFFFF);
      ahb(1'b0, 8'h1C, 32'h0);
      check(rdv, 32'h0);
      ahb(1'b1, 8'h14, 32'h00FAC688);
      ahb(1'b0, 8'h14, 32'h0);
      check(rdv, 32'h00FAC688);
      want_pll <= 9'h1FF;
      burst();
      cc(0, 8);
      cc(1, 4);
      cc(2, 2);
      cc(3, 8);
      ahb(1'b0, 8'h18, 32'h0);
      check(rdv, 32'h000001FF);
      for (int i = 0; i < 3; i++) begin
         setc(clkctl_pkg::MODE_DIV, ds[i], 4'h0, 4'h0);
         burst();
         cc(0, 8 >> i);
      end
      ahb(1'b0, 8'h00, 32'h0);
      check(rdv, 32'h00F);
      ahb(1'b1, 8'h00, 32'h00B);
      burst();
      cc(0, 8);
      setc(clkctl_pkg::MODE_ROOT, clkctl_pkg::DIV_BY1, 4'h0, 4'h0);
      burst();
      cc(0, 0);
      want_root <= 1'b1;
      burst();
      cc(0, 8);
      want_root <= 1'b0;
      setc(clkctl_pkg::MODE_ROOT, clkctl_pkg::DIV_BY1, 4'h0, 4'h1);
      burst();
      cc(0, 8);
      setc(clkctl_pkg::MODE_PASS, clkctl_pkg::DIV_BY1, 4'h0, 4'h0);
      want_pll <= 9'h1FE;
      burst();
      cc(0, 0);
      setc(clkctl_pkg::MODE_PASS, clkctl_pkg::DIV_BY1, 4'h1, 4'h0);
      burst();
      cc(0, 8);
      ahb(1'b1, 8'h00, 32'h01E);
      burst();
      cc(0, 8);
      ahb(1'b1, 8'h04, 32'h0);
      burst();
      cc(3, 0);
      cc(5, 0);
      want_sec <= 8'h01;
      burst();
      cc(3, 8);
      cc(4, 8);
      cc(5, 8);
      ahb(1'b1, 8'h08, 32'h38);
      burst();
      cc(4, 0);
      want_sec <= 8'h80;
      burst();
      cc(3, 0);
      cc(4, 8);
      ahb(1'b1, 8'h04, 32'h1);
      burst();
      cc(3, 8);
      reg_d  <= 8'hA5;
      reg_ce <= 1'b1;
      @(posedge hclk);
      reg_ce <= 1'b0;
      reg_d  <= 8'h3C;
      repeat (2) @(posedge hclk);
      check({24'h0, reg_q}, 32'hA5);
      finish_test();
   end
endmodule : fabric_clock_gating_divider_test
`default_nettype wire
